// [pkg/rsfm_consts.svh]
// Constants of the register stack frame manager
`ifndef RSFM_CONSTS_SVH
`define RSFM_CONSTS_SVH
// -----------------------------------------------------------------
// Register bank and frame sizes
// -----------------------------------------------------------------
`define RSFM_LREG_CNT     7'd64
`define RSFM_IDX_W        6
`define RSFM_FL_MAX       5'd16
`define RSFM_FL_IMPLICIT  4'h6
`define RSFM_RESERVE      10
`define RSFM_WORD_BYTES   32'h4
// -----------------------------------------------------------------
// Status word fields
// -----------------------------------------------------------------
`define RSFM_SW_FP_HI     31
`define RSFM_SW_FP_LO     25
`define RSFM_SW_FL_HI     24
`define RSFM_SW_FL_LO     21
// -----------------------------------------------------------------
// Register offsets (word addresses) and reset values
// -----------------------------------------------------------------
`define RSFM_OFS_EVENT    4'h0
`define RSFM_OFS_MASK     4'h1
`define RSFM_OFS_UB       4'h2
`define RSFM_OFS_SP       4'h3
`define RSFM_OFS_FRAME    4'h4
`define RSFM_RST_UB       32'hFFFFFFFC
`define RSFM_RST_SP       32'h00000000
`define RSFM_EV_W         4
`define RSFM_EV_FERR      0
`define RSFM_EV_PRIV      1
`define RSFM_EV_PUSH      2
`define RSFM_EV_PULL      3
`endif

// [pkg/rsfm_pkg.sv]
// Types of the register stack frame manager
package rsfm_pkg;
	// Engine states
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_PULL} rsfm_state_t;
	// Stack operation kinds
	typedef enum logic [1:0] {OP_CALL, OP_FRAME, OP_RET} rsfm_kind_t;
	// Stack operation request from the core
	typedef struct packed {
		logic        valid;
		rsfm_kind_t  kind;
		logic [3:0]  dest;
		logic [3:0]  cnt;
		logic [3:0]  len;
		logic [31:0] retPc;
		logic [31:0] retSw;
	} rsfm_op_t;
	// Word request toward data memory
	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rsfm_mem_t;
endpackage : rsfm_pkg

// [src/rsfm_top.sv]
// Register stack frame manager: local register bank, spill engine, registers
// Overview of operation
// - 64 local registers as circular buffer
// - Current frame always resident in bank
// - Frame pointer marks frame register zero
// - Frame length up to 16, code 0
// - Stack grows upward, limited by bound
// - Call starts frame of length six
// - Call saves pair, moves frame pointer
// - Dest zero at length 16 means sixteen
// - Frame op lowers frame pointer by count
// - Frame op sets length, keeps ten spare
// - Push shortfall of oldest registers out
// - Trap after push if old pointer high
// - Return reinstates preceding frame
// - Pull missing part back from memory
// - Overflow and underflow handled in hardware
// - Index is pointer plus code, mod 64
// - Bound write supervisor only, low bits zero
`timescale 1ns/100ps
`default_nettype none
`include "rsfm_consts.svh"

module rsfm_top #(
	parameter int RESERVE = `RSFM_RESERVE
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire rsfm_pkg::rsfm_op_t op,
	output logic                   opAccept_r,
	output logic                   busy_r,
	input  wire logic              regWe,
	input  wire logic [3:0]        regWrCode,
	input  wire logic [31:0]       regWdata,
	input  wire logic [3:0]        regRdCode,
	output logic [31:0]            regRdData_r,
	output logic [31:0]            statusWord_r,
	output logic                   frameErrTrap_r,
	output rsfm_pkg::rsfm_mem_t    mem_r,
	input  wire logic              memAck,
	input  wire logic [31:0]       memRdata,
	input  wire logic              supervisor,
	input  wire logic [3:0]        avsAddress,
	input  wire logic              avsRead,
	input  wire logic              avsWrite,
	input  wire logic [31:0]       avsWritedata,
	output logic [31:0]            avsReaddata_r,
	output logic                   avsWaitrequest_r,
	output logic                   irq_r
);
	// -----------------------------------------------------------------
	// Elaboration checks
	// -----------------------------------------------------------------
	// Reserve plus a full frame must fit in the bank
	if (RESERVE < 6 || RESERVE + 16 > 64) begin : g_badReserve
		$error("rsfm_top: RESERVE out of range");
	end

	// -----------------------------------------------------------------
	// Helper functions
	// -----------------------------------------------------------------
	// Absolute bank index, wraps modulo 64
	function automatic logic [5:0] absIdx(input logic [29:0] baseW, input logic [4:0] ofs);
		absIdx = baseW[5:0] + 6'(ofs);
	endfunction : absIdx

	// Length from its 4-bit code, 0 stands for 16
	function automatic logic [4:0] flLen(input logic [3:0] code);
		flLen = (code == 4'h0) ? `RSFM_FL_MAX : {1'b0, code};
	endfunction : flLen

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [31:0]           lreg [0:63];   // Local register bank
	rsfm_pkg::rsfm_state_t state_r;       // Spill engine state
	logic [29:0]           fpW_r;         // Frame pointer, word count
	logic [3:0]            flCode_r;      // Frame length code
	logic [31:0]           sp_r;          // Stack pointer, byte address
	logic [29:0]           spEnd_r;       // Transfer end, word count
	logic [31:0]           spOld_r;       // Pointer before the push
	logic [31:0]           ub_r;          // Upper stack bound
	logic [`RSFM_EV_W-1:0] ev_r;          // Sticky events
	logic [`RSFM_EV_W-1:0] mask_r;        // Interrupt mask
	logic [`RSFM_EV_W-1:0] evSet;         // Events of this cycle
	logic                  pushDone;      // Last push word acked
	logic                  pullDone;      // Last pull word acked
	logic                  privErr;       // Refused bound write

	// -----------------------------------------------------------------
	// Operation decode
	// -----------------------------------------------------------------
	wire         opGo     = op.valid && state_r == rsfm_pkg::ST_IDLE;
	wire         isCall   = opGo && op.kind == rsfm_pkg::OP_CALL;
	wire         isFrame  = opGo && op.kind == rsfm_pkg::OP_FRAME;
	wire         isRet    = opGo && op.kind == rsfm_pkg::OP_RET;
	wire  [29:0] spW      = sp_r[31:2];   // Word of next spill slot
	wire  [4:0]  callOfs  = (flCode_r == 4'h0 && op.dest == 4'h0)
	                        ? `RSFM_FL_MAX : {1'b0, op.dest};
	wire  [29:0] frameFp  = fpW_r - 30'(op.cnt);
	wire  [29:0] frameTop = frameFp + 30'(flLen(op.len)) + 30'(RESERVE);
	// Words beyond the bank must go out
	wire  [29:0] needEnd  = frameTop - 30'(`RSFM_LREG_CNT);
	wire         needPush = isFrame && (frameTop - spW > 30'(`RSFM_LREG_CNT));
	// Saved frame pointer lies just below current one
	wire  [6:0]  swFp     = op.retSw[`RSFM_SW_FP_HI:`RSFM_SW_FP_LO];
	wire  [29:0] retFp    = fpW_r - 30'(7'(fpW_r[6:0] - swFp));
	// Frame bottom below the oldest resident word
	wire         needPull = isRet && (retFp < spW);
	wire         engIdle  = state_r == rsfm_pkg::ST_IDLE;
	wire         memDone  = mem_r.req && memAck;

	// -----------------------------------------------------------------
	// Spill engine state
	// -----------------------------------------------------------------
	// Push and pull run one word per memory answer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= rsfm_pkg::ST_IDLE;
		end else begin
			case (state_r)
				rsfm_pkg::ST_IDLE: begin
					if (needPush) begin
						state_r <= rsfm_pkg::ST_PUSH;
					end else if (needPull) begin
						state_r <= rsfm_pkg::ST_PULL;
					end
				end
				rsfm_pkg::ST_PUSH: begin
					if (pushDone) begin
						state_r <= rsfm_pkg::ST_IDLE;
					end
				end
				rsfm_pkg::ST_PULL: begin
					if (pullDone) begin
						state_r <= rsfm_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= rsfm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign pushDone = state_r == rsfm_pkg::ST_PUSH && memDone && spW + 30'h1 == spEnd_r;
	assign pullDone = state_r == rsfm_pkg::ST_PULL && memDone && spW - 30'h1 == spEnd_r;

	// -----------------------------------------------------------------
	// Stall and accept
	// -----------------------------------------------------------------
	// Busy while a transfer runs
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_r     <= 1'b0;
			opAccept_r <= 1'b0;
		end else begin
			busy_r     <= needPush || needPull || (!engIdle && !pushDone && !pullDone);
			opAccept_r <= opGo;
		end
	end

	// -----------------------------------------------------------------
	// Frame pointer and frame length
	// -----------------------------------------------------------------
	// Bank is 64 words deep, so a 6-bit slice of fpW_r picks the slot
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fpW_r    <= 30'h0;
			flCode_r <= `RSFM_FL_IMPLICIT;
		end else if (isCall) begin
			fpW_r    <= fpW_r + 30'(callOfs);
			flCode_r <= `RSFM_FL_IMPLICIT;
		end else if (isFrame) begin
			fpW_r    <= frameFp;
			flCode_r <= op.len;
		end else if (isRet) begin
			fpW_r    <= retFp;
			flCode_r <= op.retSw[`RSFM_SW_FL_HI:`RSFM_SW_FL_LO];
		end
	end

	// Length code placed in the status word
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			statusWord_r <= 32'h0;
		end else begin
			statusWord_r <= 32'h0;
			statusWord_r[`RSFM_SW_FP_HI:`RSFM_SW_FP_LO] <= fpW_r[6:0];
			statusWord_r[`RSFM_SW_FL_HI:`RSFM_SW_FL_LO] <= flCode_r;
		end
	end

	// -----------------------------------------------------------------
	// Stack pointer and transfer bounds
	// -----------------------------------------------------------------
	// Pushes move the pointer upward
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sp_r    <= `RSFM_RST_SP;
			spEnd_r <= 30'h0;
			spOld_r <= `RSFM_RST_SP;
		end else if (needPush) begin
			spEnd_r <= needEnd;
			spOld_r <= sp_r;
		end else if (needPull) begin
			spEnd_r <= retFp;
		end else if (state_r == rsfm_pkg::ST_PUSH && memDone) begin
			// One word written, step up four
			sp_r <= sp_r + `RSFM_WORD_BYTES;
		end else if (state_r == rsfm_pkg::ST_PULL && memDone) begin
			// One word read back, step down four
			sp_r <= sp_r - `RSFM_WORD_BYTES;
		end else if (engIdle && !avsWaitrequest_r && avsWrite && avsAddress == `RSFM_OFS_SP) begin
			// Software may move the pointer only while idle
			sp_r <= {avsWritedata[31:2], 2'b00};
		end
	end

	// -----------------------------------------------------------------
	// Memory request
	// -----------------------------------------------------------------
	// Request held until answered, then the next word follows
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mem_r <= '0;
		end else if (needPush) begin
			mem_r.req   <= 1'b1;
			mem_r.we    <= 1'b1;
			mem_r.addr  <= sp_r;
			mem_r.wdata <= lreg[sp_r[7:2]];
		end else if (needPull) begin
			// Newest missing word comes back first
			mem_r.req   <= 1'b1;
			mem_r.we    <= 1'b0;
			mem_r.addr  <= sp_r - `RSFM_WORD_BYTES;
			mem_r.wdata <= 32'h0;
		end else if (pushDone || pullDone) begin
			mem_r <= '0;
		end else if (memDone && mem_r.we) begin
			mem_r.addr  <= sp_r + `RSFM_WORD_BYTES;
			mem_r.wdata <= lreg[6'(sp_r[7:2] + 6'h1)];
		end else if (memDone) begin
			mem_r.addr  <= sp_r - 32'h8;
		end
	end

	// -----------------------------------------------------------------
	// Local register bank
	// -----------------------------------------------------------------
	// Circular bank, pulls and calls write here
	always_ff @(posedge mclk) begin
		if (state_r == rsfm_pkg::ST_PULL && memDone) begin
			lreg[6'(sp_r[7:2] - 6'h1)] <= memRdata;
		end else if (isCall) begin
			lreg[absIdx(fpW_r, callOfs)]         <= op.retPc;
			lreg[absIdx(fpW_r, 5'(callOfs + 5'h1))] <= op.retSw;
		end else if (regWe && engIdle) begin
			lreg[absIdx(fpW_r, {1'b0, regWrCode})] <= regWdata;
		end
	end

	// Code zero reads the frame's first register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			regRdData_r <= 32'h0;
		end else begin
			regRdData_r <= lreg[absIdx(fpW_r, {1'b0, regRdCode})];
		end
	end

	// -----------------------------------------------------------------
	// Frame error trap
	// -----------------------------------------------------------------
	// Checked once the push is over
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			frameErrTrap_r <= 1'b0;
		end else begin
			frameErrTrap_r <= pushDone && spOld_r > ub_r;
		end
	end

	// -----------------------------------------------------------------
	// Upper stack bound
	// -----------------------------------------------------------------
	wire ubWrite = !avsWaitrequest_r && avsWrite && avsAddress == `RSFM_OFS_UB;
	assign privErr = ubWrite && !supervisor;

	// Supervisor only, low two bits forced clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ub_r <= `RSFM_RST_UB;
		end else if (ubWrite && supervisor) begin
			ub_r <= {avsWritedata[31:2], 2'b00};
		end
	end

	// -----------------------------------------------------------------
	// Events, mask and interrupt
	// -----------------------------------------------------------------
	always_comb begin
		evSet = '0;
		evSet[`RSFM_EV_FERR] = pushDone && spOld_r > ub_r;
		evSet[`RSFM_EV_PRIV] = privErr;
		evSet[`RSFM_EV_PUSH] = pushDone;
		evSet[`RSFM_EV_PULL] = pullDone;
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ev_r <= '0;
		end else if (!avsWaitrequest_r && avsWrite && avsAddress == `RSFM_OFS_EVENT) begin
			ev_r <= (ev_r & ~avsWritedata[`RSFM_EV_W-1:0]) | evSet;
		end else begin
			ev_r <= ev_r | evSet;
		end
	end

	// Mask register, same layout as the events
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mask_r <= '0;
		end else if (!avsWaitrequest_r && avsWrite && avsAddress == `RSFM_OFS_MASK) begin
			mask_r <= avsWritedata[`RSFM_EV_W-1:0];
		end
	end

	// Level interrupt, one cycle behind the flags
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(ev_r & mask_r);
		end
	end

	// -----------------------------------------------------------------
	// Avalon-MM slave
	// -----------------------------------------------------------------
	// One wait cycle per access keeps every answer registered
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			avsWaitrequest_r <= 1'b1;
		end else if (avsWaitrequest_r && (avsRead || avsWrite)) begin
			avsWaitrequest_r <= 1'b0;
		end else begin
			avsWaitrequest_r <= 1'b1;
		end
	end

	// Read data captured as waitrequest drops
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			avsReaddata_r <= 32'h0;
		end else if (avsWaitrequest_r && avsRead) begin
			case (avsAddress)
				`RSFM_OFS_EVENT: avsReaddata_r <= 32'(ev_r);
				`RSFM_OFS_MASK:  avsReaddata_r <= 32'(mask_r);
				`RSFM_OFS_UB:    avsReaddata_r <= ub_r;
				`RSFM_OFS_SP:    avsReaddata_r <= sp_r;
				`RSFM_OFS_FRAME: avsReaddata_r <= statusWord_r;
				default:         avsReaddata_r <= 32'h0;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_bus_onewait: assert property (@(posedge mclk) disable iff (sys_rst) // bus
		avsWaitrequest_r && (avsRead || avsWrite) |=> !avsWaitrequest_r ##1 avsWaitrequest_r)
		else $error("waitrequest not one cycle");
	a_stall_transfer: assert property (@(posedge mclk) disable iff (sys_rst)
		!engIdle && !$past(pushDone) && !$past(pullDone) |-> busy_r)
		else $error("no stall during transfer");
	a_push_step: assert property (@(posedge mclk) disable iff (sys_rst)
		state_r == rsfm_pkg::ST_PUSH && memDone |=> sp_r == $past(sp_r) + `RSFM_WORD_BYTES)
		else $error("push pointer step wrong");
	a_pull_step: assert property (@(posedge mclk) disable iff (sys_rst)
		state_r == rsfm_pkg::ST_PULL && memDone |=> sp_r == $past(sp_r) - `RSFM_WORD_BYTES)
		else $error("pull pointer step wrong");
	a_call_length: assert property (@(posedge mclk) disable iff (sys_rst)
		isCall |=> flCode_r == `RSFM_FL_IMPLICIT && fpW_r == $past(fpW_r) + 30'($past(callOfs)))
		else $error("call frame wrong");
	a_frame_lower: assert property (@(posedge mclk) disable iff (sys_rst)
		isFrame |=> fpW_r == $past(fpW_r) - 30'($past(op.cnt)) && flCode_r == $past(op.len))
		else $error("frame op wrong");
	a_bound_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(ub_r[1:0] == 2'b00) and (!supervisor && ubWrite |=> $stable(ub_r)))
		else $error("bound write wrong");
	a_reserve_kept: assert property (@(posedge mclk) disable iff (sys_rst)
		pushDone |=> engIdle && fpW_r + 30'(flLen(flCode_r)) + 30'(RESERVE) - spW
		== 30'(`RSFM_LREG_CNT))
		else $error("reserve not restored");
	a_frame_trap: assert property (@(posedge mclk) disable iff (sys_rst)
		pushDone && spOld_r > ub_r |=> frameErrTrap_r ##1 ev_r[`RSFM_EV_FERR])
		else $error("frame error missed");
	a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst) // interrupt
		|(ev_r & mask_r) |=> irq_r)
		else $error("interrupt not raised");
	a_mem_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		mem_r.req && !memAck |=> $stable(mem_r))
		else $error("memory request changed early");
	a_pull_resident: assert property (@(posedge mclk) disable iff (sys_rst)
		pullDone |=> engIdle && spW == fpW_r)
		else $error("frame not resident after pull");

endmodule : rsfm_top
`default_nettype wire

// [verif/rsfm_mem_model.sv]
// Data memory model holding the spilled part of the stack
`timescale 1ns/100ps
`default_nettype none

module rsfm_mem_model (
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire rsfm_pkg::rsfm_mem_t memReq,
	output logic                     memAck,
	output logic [31:0]              memRdata
);
	// -----------------------------------------------------------------
	// Word store
	// -----------------------------------------------------------------
	logic [31:0] store [64];  // One word per stack slot

	// Random latency; data line toggles outside a read answer
	// one word per access
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			memAck   <= 1'b0;
			memRdata <= 32'h0;
		end else begin
			memAck   <= 1'b0;
			memRdata <= ~memRdata;
			// Never answer the same request twice
			if (memReq.req && !memAck && ($urandom % 3 == 0)) begin
				memAck <= 1'b1;
				if (memReq.we) begin
					store[memReq.addr[7:2]] <= memReq.wdata;
				end else begin
					memRdata <= store[memReq.addr[7:2]];
				end
			end
		end
	end
endmodule : rsfm_mem_model

`default_nettype wire

// [verif/rsfm_tb_top.sv]
// Self-checking bench of the register stack frame manager
`timescale 1ns/100ps
`default_nettype none
`include "rsfm_consts.svh"

module rsfm_tb_top;
	// Large reserve so that short frames already spill
	localparam int RES = 48;
	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	logic                mclk = 1'b0;
	logic                sysRst = 1'b1;
	rsfm_pkg::rsfm_op_t  op = '0;
	logic                opAccept, busy, trap, memAck, irq, avsWaitrequest;
	logic                regWe = 1'b0;
	logic [3:0]          regWrCode = 4'h0;
	logic [31:0]         regWdata = 32'h0;
	logic [3:0]          regRdCode = 4'h0;
	logic [31:0]         regRdData, statusWord, memRdata, avsReaddata;
	rsfm_pkg::rsfm_mem_t memBus;
	logic                supervisor = 1'b0;
	logic [3:0]          avsAddress = 4'h0;
	logic                avsRead = 1'b0;
	logic                avsWrite = 1'b0;
	logic [31:0]         avsWritedata = 32'h0;
	logic                rdStrobe = 1'b0;  // Register read launched
	logic                rdD1 = 1'b0;      // Read result now settled
	int                  mismatches = 0;
	int                  cmpCount = 0;
	int                  trapCnt = 0;
	logic [64:0]         avQ [$];          // Expected bus read data
	logic [64:0]         regQ [$];         // Expected bank read data
	logic [64:0]         memQ [$];         // Expected {we, addr, wdata}

	// Free-running clock, 10 ns
	always #5 mclk = ~mclk;

	rsfm_top #(.RESERVE(RES)) dut (
		.mclk(mclk), .sys_rst(sysRst), .op(op), .opAccept_r(opAccept), .busy_r(busy),
		.regWe(regWe), .regWrCode(regWrCode), .regWdata(regWdata), .regRdCode(regRdCode),
		.regRdData_r(regRdData), .statusWord_r(statusWord), .frameErrTrap_r(trap),
		.mem_r(memBus), .memAck(memAck), .memRdata(memRdata), .supervisor(supervisor),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsReaddata_r(avsReaddata),
		.avsWaitrequest_r(avsWaitrequest), .irq_r(irq)
	);

	rsfm_mem_model mem (
		.mclk(mclk), .sys_rst(sysRst), .memReq(memBus), .memAck(memAck), .memRdata(memRdata)
	);

	// -----------------------------------------------------------------
	// Compare and report
	// -----------------------------------------------------------------
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		cmpCount++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task finish_test;
		$display("Mismatches %0d, comparisons %0d", mismatches, cmpCount);
		if (mismatches == 0 && cmpCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// Status word image of a frame
	function automatic logic [31:0] swv(input logic [6:0] framePtr, input logic [3:0] flc);
		return {framePtr, flc, 21'h0};
	endfunction : swv

	// Watcher: takes the oldest note whenever a result shows
	always @(posedge mclk) begin
		if (avsRead && avsWaitrequest === 1'b0) chk(avsReaddata, avQ.pop_front());
		if (rdD1) chk(regRdData, regQ.pop_front());
		// Reads carry no data of ours to compare
		if (memBus.req && memAck === 1'b1)
			chk({memBus.we, memBus.addr, memBus.we ? memBus.wdata : 32'h0}, memQ.pop_front());
		if (trap === 1'b1) trapCnt++;
		rdD1 <= rdStrobe;
	end

	// -----------------------------------------------------------------
	// Drivers
	// -----------------------------------------------------------------
	// One bus access, held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avsRead <= ~wr;
		avsWrite <= wr;
		avsAddress <= a;
		avsWritedata <= d;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (avsWaitrequest === 1'b0) break;
		end
		if (n == 50) begin mismatches++; finish_test(); end
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask : av

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		avQ.push_back({33'h0, e});
		av(1'b0, a, 32'h0);
	endtask : rd

	// Frame-relative bank write and read
	task automatic rw(input logic [3:0] c, input logic [31:0] d);
		@(posedge mclk);
		regWe <= 1'b1;
		regWrCode <= c;
		regWdata <= d;
		@(posedge mclk);
		regWe <= 1'b0;
	endtask : rw

	task automatic rr(input logic [3:0] c, input logic [31:0] e);
		regQ.push_back({33'h0, e});
		@(posedge mclk);
		regRdCode <= c;
		rdStrobe <= 1'b1;
		@(posedge mclk);
		rdStrobe <= 1'b0;
		@(posedge mclk);
	endtask : rr

	// Stack operation; waits for accept and for the end of any transfer
	task automatic doOp(input rsfm_pkg::rsfm_kind_t k, input logic [3:0] dst, input logic [3:0] cnt,
			input logic [3:0] len, input logic [31:0] pc, input logic [31:0] sw, input logic eb);
		int   n;
		logic sawBusy;
		@(posedge mclk);
		op <= '{1'b1, k, dst, cnt, len, pc, sw};
		@(posedge mclk);
		op.valid <= 1'b0;
		for (n = 0; n < 20 && opAccept !== 1'b1; n++) @(posedge mclk);
		if (n == 20) begin mismatches++; finish_test(); end
		sawBusy = (busy === 1'b1);
		for (n = 0; n < 500 && busy !== 1'b0; n++) @(posedge mclk);
		if (n == 500) begin mismatches++; finish_test(); end
		chk(sawBusy, eb);
	endtask : doOp

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		int          i;
		logic [31:0] d [7];
		logic [31:0] pc, sw, pc2;
		void'($urandom(32'h25eb26df));
		for (i = 0; i < 7; i++) d[i] = $urandom;
		pc = $urandom;
		sw = $urandom;
		pc2 = $urandom;
		repeat (16) @(posedge mclk);
		sysRst <= 1'b0;
		// Reset values and an unmapped place
		rd(`RSFM_OFS_UB, `RSFM_RST_UB);
		rd(`RSFM_OFS_SP, `RSFM_RST_SP);
		rd(`RSFM_OFS_FRAME, swv(7'h0, 4'h6));
		rd(4'hF, 32'h0);
		// User bound write refused, raises a masked-in interrupt
		av(1'b1, `RSFM_OFS_UB, 32'h0);
		rd(`RSFM_OFS_UB, `RSFM_RST_UB);
		rd(`RSFM_OFS_EVENT, 32'h2);
		av(1'b1, `RSFM_OFS_MASK, 32'h2);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1);
		av(1'b1, `RSFM_OFS_EVENT, 32'h2);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		// Supervisor bound write keeps the low bits clear
		supervisor <= 1'b1;
		av(1'b1, `RSFM_OFS_UB, 32'h7);
		rd(`RSFM_OFS_UB, 32'h4);
		for (i = 0; i < 7; i++) rw(i[3:0], d[i]);
		rr(4'h3, d[3]);
		// Call: pair saved at the destination, which becomes register zero
		doOp(rsfm_pkg::OP_CALL, 4'h9, 4'h0, 4'h0, pc, sw, 1'b0);
		rd(`RSFM_OFS_FRAME, swv(7'h9, 4'h6));
		chk(statusWord, swv(7'h9, 4'h6));
		rr(4'h0, pc);
		rr(4'h1, sw);
		// Frame with shortfall of two: oldest slots go out upward
		memQ.push_back({1'b1, 32'h0, d[0]});
		memQ.push_back({1'b1, 32'h4, d[1]});
		doOp(rsfm_pkg::OP_FRAME, 4'h0, 4'h2, 4'hB, 32'h0, 32'h0, 1'b1);
		rd(`RSFM_OFS_SP, 32'h8);
		chk(trapCnt, 0);
		rr(4'h2, pc);
		rd(`RSFM_OFS_FRAME, swv(7'h7, 4'hB));
		// Full frame of sixteen: five more words, old pointer above bound
		for (i = 2; i < 7; i++) memQ.push_back({1'b1, 32'(i * 4), d[i]});
		doOp(rsfm_pkg::OP_FRAME, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 1'b1);
		rd(`RSFM_OFS_SP, 32'h1C);
		chk(trapCnt, 1);
		rd(`RSFM_OFS_FRAME, swv(7'h7, 4'h0));
		// Destination zero after a frame of sixteen lands past fifteen
		doOp(rsfm_pkg::OP_CALL, 4'h0, 4'h0, 4'h0, pc2, sw, 1'b0);
		rd(`RSFM_OFS_FRAME, swv(7'h17, 4'h6));
		rr(4'h0, pc2);
		// Return to the first frame: pulled back in reverse order
		for (i = 6; i >= 0; i--) memQ.push_back({1'b0, 32'(i * 4), 32'h0});
		doOp(rsfm_pkg::OP_RET, 4'h0, 4'h0, 4'h0, 32'h0, swv(7'h0, 4'h6), 1'b1);
		rd(`RSFM_OFS_SP, 32'h0);
		rd(`RSFM_OFS_FRAME, swv(7'h0, 4'h6));
		for (i = 0; i < 7; i++) rr(i[3:0], d[i]);
		// Sticky events of trap, push and pull; masked off the line
		rd(`RSFM_OFS_EVENT, 32'hD);
		chk(irq, 1'b0);
		chk(memQ.size(), 0);
		repeat (4) @(posedge mclk);
		finish_test();
	end
endmodule : rsfm_tb_top

`default_nettype wire
